// [common/ovr_map.svh]
`ifndef OVR_MAP_SVH
`define OVR_MAP_SVH

// register indices; byte address is four times the index
`define OVR_IDX_CTRL      12'h000
`define OVR_IDX_THRESH    12'h001
`define OVR_IDX_STRETCH   12'h002
`define OVR_IDX_STATUS    12'h003
`define OVR_IDX_IRQ_STAT  12'h004
`define OVR_IDX_IRQ_MASK  12'h005
`define OVR_IDX_SPAN      12'h006
`define OVR_IDX_TRIM_BASE 12'h344
`define OVR_TRIM_COUNT    6

// control fields
`define OVR_CTRL_DUAL     0
`define OVR_CTRL_FG       1
`define OVR_CTRL_START    2
`define OVR_CTRL_INSEL    3
`define OVR_CTRL_W        4
`define OVR_CTRL_RST      4'h3

// threshold, stretch and span fields
`define OVR_THR_HI_LSB    0
`define OVR_THR_LO_LSB    8
`define OVR_THRESH_RST    16'h40e4
`define OVR_STRETCH_RST   3'h0
`define OVR_STRETCH_BASE  11'h008
`define OVR_SPAN_A_LSB    0
`define OVR_SPAN_B_LSB    8
`define OVR_SPAN_RST      16'h8080
`define OVR_TRIM_RST      8'h00

// interrupt bits: flags 0..3 rising, 4 calibration done
`define OVR_IRQ_W         5
`define OVR_IRQ_CAL       4

// trim slots relative to the trim base
`define OVR_TRIM_ADUAL    0
`define OVR_TRIM_ASINGLE  2
`define OVR_TRIM_CORE_B   4

// timing counts in device-clock cycles
`define OVR_CAL_CYCLES    64
`define OVR_QUIET_CYCLES  65536

`endif

// [common/ovr_pkg.sv]
package ovr_pkg;

	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} cal_state_t;

	typedef logic [7:0] trim_t;

endpackage

// [common/ovr_link_if.sv]
`timescale 1ns/1ps

// over-range pins and sample stream between converter and logic device
interface ovr_link_if #(
	parameter int SAMPLE_W = 12
);
	logic                dual_mode;
	logic                samp_valid;
	logic [SAMPLE_W-1:0] samp_a;
	logic [SAMPLE_W-1:0] samp_b;
	logic                chan_a_high_flag;
	logic                chan_a_low_flag;
	logic                chan_b_high_flag;
	logic                chan_b_low_flag;

	modport dev (
		output dual_mode, samp_valid, samp_a, samp_b,
		output chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag
	);
	modport mon (
		input dual_mode, samp_valid, samp_a, samp_b,
		input chan_a_high_flag, chan_a_low_flag, chan_b_high_flag, chan_b_low_flag
	);
endinterface

// [src/ovr_device.sv]
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "ovr_map.svh"

// Operation
// - compare sample magnitude with two thresholds
// - one threshold pair serves both channels
// - seven-bit magnitude, most negative saturates
// - flag set when magnitude reaches threshold
// - two flags per channel, index0 high
// - monitor ORs channels per threshold, single mode
// - stretch length eight times two to select
// - high near full scale, low near -12dBFS
// - raise gain while low flag stays quiet
// - samples are signed two's complement codes
// - dual rising edge, single both edges
// - foreground offset trims per core, input
// - software trims both cores together, single mode
// - separate span trim for each input
// - foreground halts data, background keeps converting
module ovr_device
	import ovr_pkg::*;
#(
	parameter int SAMPLE_W   = 12,
	parameter int CAL_CYCLES = `OVR_CAL_CYCLES
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [15:0]         wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output      logic [31:0]         wb_dat_o,
	output      logic                wb_ack_o,
	output      logic                irq_o,
	input  wire logic                conv_valid_i,
	input  wire logic [SAMPLE_W-1:0] conv_a_i,
	input  wire logic [SAMPLE_W-1:0] conv_b_i,
	output      logic [7:0]          input_a_span_trim_o,
	output      logic [7:0]          input_b_span_trim_o,
	ovr_link_if.dev                  link
);

	if (SAMPLE_W < 8 || SAMPLE_W > 24) begin : g_bad_width
		$error("sample width must be 8 to 24");
	end
	if (CAL_CYCLES < 1 || CAL_CYCLES > 65536) begin : g_bad_cal
		$error("calibration length must be 1 to 65536 cycles");
	end

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
	                                      input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (wd & m);
	endfunction

	// magnitude of the top eight code bits; -128 has no +128 so it clips
	function automatic logic [6:0] mag7(input logic [7:0] u);
		logic [7:0] neg;
		neg = 8'(~u + 8'h01);
		if (!u[7])
			mag7 = u[6:0];
		else if (neg[7])
			mag7 = 7'h7f;
		else
			mag7 = neg[6:0];
	endfunction

	// signed trim added to a code, clipped to the code range
	function automatic logic [SAMPLE_W-1:0] trim_add(input logic [SAMPLE_W-1:0] s,
	                                                 input trim_t t);
		logic [SAMPLE_W:0] sum;
		sum = {s[SAMPLE_W-1], s} + {{(SAMPLE_W-7){t[7]}}, t};
		if (sum[SAMPLE_W] != sum[SAMPLE_W-1])
			trim_add = {sum[SAMPLE_W], {(SAMPLE_W-1){~sum[SAMPLE_W]}}};
		else
			trim_add = sum[SAMPLE_W-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register bus

	logic [11:0]             idx;
	logic                    req;
	logic                    wr;
	logic [31:0]             wmerged;
	logic [31:0]             wclr;
	logic [31:0]             rd;
	logic                    ack_q,     ack_d;
	logic [31:0]             dat_q,     dat_d;
	logic [`OVR_CTRL_W-1:0]  ctrl_q,    ctrl_d;
	logic [15:0]             thresh_q,  thresh_d;
	logic [2:0]              stretch_q, stretch_d;
	logic [15:0]             span_q,    span_d;
	logic [`OVR_IRQ_W-1:0]   ist_q,     ist_d;
	logic [`OVR_IRQ_W-1:0]   imask_q,   imask_d;
	logic                    irq_q,     irq_d;
	trim_t                   trim_q [`OVR_TRIM_COUNT];
	trim_t                   trim_d [`OVR_TRIM_COUNT];
	logic [`OVR_IRQ_W-1:0]   ev_irq;
	cal_state_t              cal_q,     cal_d;

	assign idx = wb_adr_i[13:2];
	assign req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master sees ack
	assign wr  = req & wb_we_i & ack_q;

	// read decode; unmapped words read zero
	always_comb begin
		rd = 32'h0;
		case (idx)
			`OVR_IDX_CTRL:     rd = 32'(ctrl_q);
			`OVR_IDX_THRESH:   rd = 32'(thresh_q);
			`OVR_IDX_STRETCH:  rd = 32'(stretch_q);
			`OVR_IDX_STATUS:   rd = 32'(cal_q == CAL_RUN);
			`OVR_IDX_IRQ_STAT: rd = 32'(ist_q);
			`OVR_IDX_IRQ_MASK: rd = 32'(imask_q);
			`OVR_IDX_SPAN:     rd = 32'(span_q);
			default: begin
				for (int k = 0; k < `OVR_TRIM_COUNT; k++) begin
					if (idx == 12'(`OVR_IDX_TRIM_BASE + k))
						rd = 32'(trim_q[k]);
				end
			end
		endcase
	end

	assign wmerged = merge(rd, wb_dat_i, wb_sel_i);
	// clear mask from the selected lanes only, so an unselected lane clears nothing
	assign wclr    = merge(32'h0, wb_dat_i, wb_sel_i);

	// next register values
	always_comb begin
		ack_d     = req & ~ack_q;
		dat_d     = (req & ~ack_q) ? rd : dat_q;
		ctrl_d    = ctrl_q;
		ctrl_d[`OVR_CTRL_START] = 1'b0;  // start is a self-clearing strobe
		thresh_d  = thresh_q;
		stretch_d = stretch_q;
		span_d    = span_q;
		imask_d   = imask_q;
		ist_d     = ist_q;
		trim_d    = trim_q;
		if (wr) begin
			case (idx)
				`OVR_IDX_CTRL:     ctrl_d    = wmerged[`OVR_CTRL_W-1:0];
				`OVR_IDX_THRESH:   thresh_d  = wmerged[15:0];
				`OVR_IDX_STRETCH:  stretch_d = wmerged[2:0];
				`OVR_IDX_IRQ_MASK: imask_d   = wmerged[`OVR_IRQ_W-1:0];
				`OVR_IDX_IRQ_STAT: ist_d     = ist_q & ~wclr[`OVR_IRQ_W-1:0];
				`OVR_IDX_SPAN:     span_d    = wmerged[15:0];
				default: begin
					for (int k = 0; k < `OVR_TRIM_COUNT; k++) begin
						if (idx == 12'(`OVR_IDX_TRIM_BASE + k))
							trim_d[k] = wmerged[7:0];
					end
				end
			endcase
		end
		ist_d = ist_d | ev_irq;  // a new event beats a same-cycle clear
		irq_d = |(ist_d & imask_d);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q     <= 1'b0;
			dat_q     <= 32'h0;
			ctrl_q    <= `OVR_CTRL_RST;
			thresh_q  <= `OVR_THRESH_RST;
			stretch_q <= `OVR_STRETCH_RST;
			span_q    <= `OVR_SPAN_RST;
			ist_q     <= '0;
			imask_q   <= '0;
			irq_q     <= 1'b0;
			for (int k = 0; k < `OVR_TRIM_COUNT; k++)
				trim_q[k] <= `OVR_TRIM_RST;
		end else begin
			ack_q     <= ack_d;
			dat_q     <= dat_d;
			ctrl_q    <= ctrl_d;
			thresh_q  <= thresh_d;
			stretch_q <= stretch_d;
			span_q    <= span_d;
			ist_q     <= ist_d;
			imask_q   <= imask_d;
			irq_q     <= irq_d;
			trim_q    <= trim_d;
		end
	end

	assign wb_ack_o            = ack_q;
	assign wb_dat_o            = dat_q;
	assign irq_o               = irq_q;
	assign input_a_span_trim_o = span_q[`OVR_SPAN_A_LSB +: 8];
	assign input_b_span_trim_o = span_q[`OVR_SPAN_B_LSB +: 8];

	////////////////////////////////////////////////////////////////////////
	// calibration sequencer

	logic        dual;
	logic        fg;
	logic [15:0] cal_cnt_q, cal_cnt_d;

	assign dual = ctrl_q[`OVR_CTRL_DUAL];
	assign fg   = ctrl_q[`OVR_CTRL_FG];

	// background mode never stops the data, so start is ignored there
	always_comb begin
		cal_d     = cal_q;
		cal_cnt_d = cal_cnt_q;
		ev_irq[`OVR_IRQ_CAL] = 1'b0;
		case (cal_q)
			CAL_IDLE: begin
				if (ctrl_q[`OVR_CTRL_START] && fg) begin
					cal_d     = CAL_RUN;
					cal_cnt_d = 16'(CAL_CYCLES - 1);
				end
			end
			CAL_RUN: begin
				if (cal_cnt_q == 16'h0) begin
					cal_d = CAL_IDLE;
					ev_irq[`OVR_IRQ_CAL] = 1'b1;
				end else begin
					cal_cnt_d = cal_cnt_q - 16'h1;
				end
			end
			default: cal_d = CAL_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_q     <= CAL_IDLE;
			cal_cnt_q <= 16'h0;
		end else begin
			cal_q     <= cal_d;
			cal_cnt_q <= cal_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample path: trim, then magnitude compare

	// port a is core A (rising edge); port b is core B, which in single mode
	// carries the falling-edge sample of the same input
	trim_t               trim_a;
	trim_t               trim_b;
	logic                insel;
	logic [SAMPLE_W-1:0] smp_a_q, smp_a_d, smp_b_q, smp_b_d;
	logic                vld_q, vld_d, dual_q;

	assign insel = ctrl_q[`OVR_CTRL_INSEL];

	// trims only act in foreground mode; background calibration owns offset
	always_comb begin
		trim_a = 8'h00;
		trim_b = 8'h00;
		if (fg) begin
			trim_a = dual ? trim_q[`OVR_TRIM_ADUAL]
			              : trim_q[`OVR_TRIM_ASINGLE + int'(insel)];
			trim_b = dual ? trim_q[`OVR_TRIM_CORE_B + 1]
			              : trim_q[`OVR_TRIM_CORE_B + int'(insel)];
		end
		vld_d   = conv_valid_i & (cal_q == CAL_IDLE);
		smp_a_d = vld_d ? trim_add(conv_a_i, trim_a) : smp_a_q;
		smp_b_d = vld_d ? trim_add(conv_b_i, trim_b) : smp_b_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vld_q   <= 1'b0;
			smp_a_q <= '0;
			smp_b_q <= '0;
			dual_q  <= 1'b1;
		end else begin
			vld_q   <= vld_d;
			smp_a_q <= smp_a_d;
			smp_b_q <= smp_b_d;
			dual_q  <= dual;
		end
	end

	// magnitude doubled so 8-bit thresholds span the 7-bit magnitude
	logic [7:0] mag2 [2];
	logic [3:0] ev;
	logic [3:0] flag_q;
	logic [3:0] flag_d;
	logic [10:0] len;

	assign mag2[0] = {mag7(smp_a_q[SAMPLE_W-1 -: 8]), 1'b0};
	assign mag2[1] = {mag7(smp_b_q[SAMPLE_W-1 -: 8]), 1'b0};
	assign len     = `OVR_STRETCH_BASE << stretch_q;

	// flag index: channel * 2 + threshold, threshold 0 high, 1 low
	for (genvar i = 0; i < 4; i++) begin : g_flag
		logic [10:0] cnt_q, cnt_d;

		assign ev[i] = vld_q & (mag2[i/2] >= thresh_q[(i%2)*8 +: 8]);

		always_comb begin
			if (ev[i])
				cnt_d = len;
			else if (cnt_q != 11'h0)
				cnt_d = cnt_q - 11'h1;
			else
				cnt_d = 11'h0;
			flag_d[i]    = cnt_d != 11'h0;
			ev_irq[i]    = flag_d[i] & ~flag_q[i];
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt_q     <= 11'h0;
				flag_q[i] <= 1'b0;
			end else begin
				cnt_q     <= cnt_d;
				flag_q[i] <= flag_d[i];
			end
		end
	end

	// link outputs, all straight from flops
	assign link.dual_mode        = dual_q;
	assign link.samp_valid       = vld_q;
	assign link.samp_a           = smp_a_q;
	assign link.samp_b           = smp_b_q;
	assign link.chan_a_high_flag = flag_q[0];
	assign link.chan_a_low_flag  = flag_q[1];
	assign link.chan_b_high_flag = flag_q[2];
	assign link.chan_b_low_flag  = flag_q[3];

endmodule

// [src/ovr_monitor.sv]
`timescale 1ns/1ps
`include "ovr_map.svh"

// downstream logic watching the over-range flags and deciding gain moves
module ovr_monitor
	import ovr_pkg::*;
#(
	parameter int SAMPLE_W     = 12,
	parameter int QUIET_CYCLES = `OVR_QUIET_CYCLES
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	ovr_link_if.mon                  link,
	output      logic [1:0]          high_over_o,
	output      logic [1:0]          low_over_o,
	output      logic                gain_down_o,
	output      logic                gain_up_o,
	output      logic                data_valid_o,
	output      logic [SAMPLE_W-1:0] data_a_o,
	output      logic [SAMPLE_W-1:0] data_b_o
);

	if (QUIET_CYCLES < 2 || QUIET_CYCLES > 2**30) begin : g_bad_quiet
		$error("quiet length out of range");
	end

	logic [1:0]          hi_q, hi_d, lo_q, lo_d;
	logic                down_q, down_d, up_q, up_d;
	logic [30:0]         quiet_q, quiet_d;
	logic                vld_q;
	logic [SAMPLE_W-1:0] a_q, b_q;

	////////////////////////////////////////////////////////////////////////
	// per-threshold status and gain decisions

	always_comb begin
		hi_d = {link.chan_b_high_flag, link.chan_a_high_flag};
		lo_d = {link.chan_b_low_flag, link.chan_a_low_flag};
		if (!link.dual_mode) begin
			// both cores cover one input, so either may see the peak
			hi_d = {2{link.chan_a_high_flag | link.chan_b_high_flag}};
			lo_d = {2{link.chan_a_low_flag | link.chan_b_low_flag}};
		end
		// high threshold sits near full scale: cut gain on a new trip
		down_d = (|hi_d) & ~(|hi_q);
		// low flag quiet for the whole window: ask for more gain, then rearm
		up_d    = 1'b0;
		quiet_d = quiet_q + 31'h1;
		if (|lo_d)
			quiet_d = 31'h0;
		else if (quiet_q == 31'(QUIET_CYCLES - 1)) begin
			up_d    = 1'b1;
			quiet_d = 31'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hi_q    <= 2'h0;
			lo_q    <= 2'h0;
			down_q  <= 1'b0;
			up_q    <= 1'b0;
			quiet_q <= 31'h0;
			vld_q   <= 1'b0;
			a_q     <= '0;
			b_q     <= '0;
		end else begin
			hi_q    <= hi_d;
			lo_q    <= lo_d;
			down_q  <= down_d;
			up_q    <= up_d;
			quiet_q <= quiet_d;
			vld_q   <= link.samp_valid;
			a_q     <= link.samp_a;
			b_q     <= link.samp_b;
		end
	end

	assign high_over_o  = hi_q;
	assign low_over_o   = lo_q;
	assign gain_down_o  = down_q;
	assign gain_up_o    = up_q;
	assign data_valid_o = vld_q;
	assign data_a_o     = a_q;
	assign data_b_o     = b_q;

endmodule

// [testbench/ovr_link_sva.sv]
`timescale 1ns/1ps

// watches the over-range pins that the logic device sees
module ovr_link_sva #(
	parameter int SAMPLE_W = 12
) (
	input wire logic                clk_i,
	input wire logic                rst_i,
	input wire logic                dual_mode,
	input wire logic                samp_valid,
	input wire logic [SAMPLE_W-1:0] samp_a,
	input wire logic [SAMPLE_W-1:0] samp_b,
	input wire logic                chan_a_high_flag,
	input wire logic                chan_a_low_flag,
	input wire logic                chan_b_high_flag,
	input wire logic                chan_b_low_flag
);
	logic [10:0] quiet_q;
	logic [10:0] quiet_d;

	// magnitude of the top code byte, most negative saturates
	function automatic logic [6:0] mag7(input logic [7:0] t);
		if (t == 8'h80)
			return 7'h7f;
		return t[7] ? 7'(-t) : t[6:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// cycles since any sample; never exceeds cycles since an event
	always_comb begin
		quiet_d = quiet_q;
		if (samp_valid)
			quiet_d = 11'h000;
		else if (quiet_q != 11'h7ff)
			quiet_d = quiet_q + 11'h001;
	end
	always_ff @(posedge clk_i) begin
		quiet_q <= rst_i ? 11'h000 : quiet_d;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	// full scale trips any threshold up to 254, the bench's ceiling
	sequence s_full_a;
		samp_valid && mag7(samp_a[SAMPLE_W-1 -: 8]) == 7'h7f;
	endsequence
	sequence s_full_b;
		samp_valid && dual_mode && mag7(samp_b[SAMPLE_W-1 -: 8]) == 7'h7f;
	endsequence

	chk_rise_a_high: assert property ($rose(chan_a_high_flag) |-> $past(samp_valid))
		else $error("a high flag rose with no sample");
	chk_rise_b_high: assert property ($rose(chan_b_high_flag) |-> $past(samp_valid))
		else $error("b high flag rose with no sample");
	chk_rise_b_low: assert property ($rose(chan_b_low_flag) |-> $past(samp_valid))
		else $error("b low flag rose with no sample");
	chk_min_a_low: assert property ($rose(chan_a_low_flag) |-> chan_a_low_flag [*8])
		else $error("a low flag shorter than eight cycles");
	chk_max_stretch: assert property (quiet_q >= 11'd1024 |->
		!(chan_a_high_flag || chan_a_low_flag || chan_b_high_flag || chan_b_low_flag))
		else $error("flag held past the longest stretch");
	chk_full_a_hold: assert property (s_full_a |=> (chan_a_high_flag && chan_a_low_flag) [*8])
		else $error("full scale a sample not flagged for eight cycles");
	chk_full_b_flag: assert property (s_full_b |=> chan_b_high_flag && chan_b_low_flag)
		else $error("full scale b sample not flagged");
	chk_idle_hold: assert property (!samp_valid |-> $stable(samp_a) && $stable(samp_b))
		else $error("sample changed while not valid");
endmodule

// [testbench/adc_overrange_detect_and_trim_tb_top.sv]
`timescale 1ns/1ps
`include "ovr_map.svh"

module adc_overrange_detect_and_trim_tb_top;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic        cv = 0;
	logic [15:0] adr = 0;
	logic [31:0] dat = 0;
	logic [31:0] rd;
	logic [31:0] dat_o;
	logic [11:0] ca = 0;
	logic [11:0] cb = 0;
	logic        ack;
	logic        irq;
	logic        gdn;
	logic        gup;
	logic [7:0]  spa;
	logic [7:0]  spb;
	logic [1:0]  hov;
	logic [1:0]  lov;
	logic [3:0]  sel = 0;
	logic [3:0]  lanes = 4'hf;
	logic        dvo;
	logic [11:0] dao;
	logic [11:0] dbo;
	logic [11:0] corner [6] = '{12'h7f0, 12'h000, 12'h900, 12'h800, 12'h200, 12'h1f0};
	integer      n_fail = 0;
	integer      samples_checked = 0;
	integer      seed = 32'h1b0936d3;

	ovr_link_if #(.SAMPLE_W(12)) link ();

	// free-running 100 MHz clock
	always #5 clk_i = ~clk_i;

	ovr_device #(.SAMPLE_W(12), .CAL_CYCLES(16)) u_ovr_device (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq), .conv_valid_i(cv),
		.conv_a_i(ca), .conv_b_i(cb), .input_a_span_trim_o(spa), .input_b_span_trim_o(spb),
		.link(link));
	ovr_monitor #(.SAMPLE_W(12), .QUIET_CYCLES(16)) u_ovr_monitor (.clk_i(clk_i),
		.rst_i(rst_i), .link(link), .high_over_o(hov), .low_over_o(lov), .gain_down_o(gdn),
		.gain_up_o(gup), .data_valid_o(dvo), .data_a_o(dao), .data_b_o(dbo));
	ovr_link_sva #(.SAMPLE_W(12)) u_ovr_link_sva (.clk_i(clk_i), .rst_i(rst_i),
		.dual_mode(link.dual_mode), .samp_valid(link.samp_valid), .samp_a(link.samp_a),
		.samp_b(link.samp_b), .chan_a_high_flag(link.chan_a_high_flag),
		.chan_a_low_flag(link.chan_a_low_flag), .chan_b_high_flag(link.chan_b_high_flag),
		.chan_b_low_flag(link.chan_b_low_flag));

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("compares %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= lanes;
		adr <= {2'b00, idx, 2'b00};
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (n >= 40)
			n_fail++;
		rd = dat_o;
		cyc <= 0;
		stb <= 0;
	endtask

	task automatic rdchk(input logic [11:0] idx, input logic [31:0] e);
		wb(0, idx, 0);
		check(rd, e);
	endtask

	// one sample, then wait until its flags have landed
	task automatic put(input logic [11:0] a, input logic [11:0] b);
		@(posedge clk_i);
		cv <= 1;
		ca <= a;
		cb <= b;
		@(posedge clk_i);
		cv <= 0;
		@(posedge clk_i);
		#1;
	endtask

	task automatic pulse(output integer n);
		n = 0;
		while (link.chan_a_high_flag === 1'b1 && n < 1100) begin
			n++;
			@(posedge clk_i);
			#1;
		end
	endtask

	function automatic logic ev(input logic [11:0] c, input logic [7:0] th);
		logic [7:0] t;
		t = c[11:4];
		if (t == 8'h80)
			t = 8'h7f;
		else if (t[7])
			t = -t;
		return {t[6:0], 1'b0} >= th;
	endfunction

	// a hang counts as a mismatch
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		integer i;
		integer n;
		logic [7:0] h;
		logic [7:0] l;
		logic [11:0] a;
		logic [11:0] b;
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		rdchk(`OVR_IDX_CTRL, 32'h3);
		rdchk(`OVR_IDX_THRESH, 32'h40e4);
		rdchk(`OVR_IDX_STRETCH, 0);
		rdchk(`OVR_IDX_SPAN, 32'h8080);
		rdchk(`OVR_IDX_IRQ_MASK, 0);
		rdchk(12'h34a, 0);
		wb(1, `OVR_IDX_TRIM_BASE + 12'h001, 32'h5a);
		rdchk(`OVR_IDX_TRIM_BASE + 12'h001, 32'h5a);
		wb(1, `OVR_IDX_SPAN, 32'h12ab);
		@(posedge clk_i);
		#1;
		check({spb, spa}, 32'h12ab);
		// dual trims: a clips at the top code, b steps down by sixteen
		wb(1, `OVR_IDX_TRIM_BASE, 32'h10);
		wb(1, `OVR_IDX_TRIM_BASE + 12'h005, 32'hf0);
		put(12'h7f8, 12'h100);
		check({link.samp_b, link.samp_a}, {12'h0f0, 12'h7ff});
		wb(1, `OVR_IDX_TRIM_BASE, 0);
		wb(1, `OVR_IDX_TRIM_BASE + 12'h005, 0);
		repeat (10) @(posedge clk_i);
		// corner codes at default thresholds, then random ones kept below 255
		for (i = 0; i < 18; i++) begin
			a = (i < 6) ? corner[i] : 12'($random(seed));
			b = (i < 6) ? corner[5-i] : 12'($random(seed));
			h = (i < 6) ? 8'he4 : 8'({$random(seed)} % 255);
			l = (i < 6) ? 8'h40 : 8'({$random(seed)} % 255);
			wb(1, `OVR_IDX_THRESH, {16'h0, l, h});
			put(a, b);
			check(link.samp_a, a);
			check({link.chan_b_low_flag, link.chan_b_high_flag, link.chan_a_low_flag,
				link.chan_a_high_flag}, {ev(b, l), ev(b, h), ev(a, l), ev(a, h)});
			check({dvo, dbo, dao}, {1'b1, b, a});
			@(posedge clk_i);
			#1;
			check({gdn, hov, lov}, {ev(a, h) | ev(b, h), ev(b, h), ev(a, h), ev(b, l), ev(a, l)});
			repeat (10) @(posedge clk_i);
		end
		check(irq, 0);
		wb(1, `OVR_IDX_IRQ_MASK, 32'h1);
		@(posedge clk_i);
		#1;
		check(irq, 1);
		// a clear on an unselected lane must leave the status alone
		lanes = 4'he;
		wb(1, `OVR_IDX_IRQ_STAT, 32'h1f);
		lanes = 4'hf;
		@(posedge clk_i);
		#1;
		check(irq, 1);
		wb(1, `OVR_IDX_IRQ_STAT, 32'h1f);
		rdchk(`OVR_IDX_IRQ_STAT, 0);
		check(irq, 0);
		// every stretch setting; the first also restarts mid-pulse
		for (i = 0; i < 8; i++) begin
			wb(1, `OVR_IDX_STRETCH, i);
			put(12'h800, 12'h000);
			if (i == 0) begin
				repeat (3) @(posedge clk_i);
				put(12'h800, 12'h000);
			end
			pulse(n);
			check(n, 8 << i);
			repeat (4) @(posedge clk_i);
		end
		wb(1, `OVR_IDX_STRETCH, 0);
		wb(1, `OVR_IDX_CTRL, 32'h2);
		// single mode: both cores' trims move together
		wb(1, `OVR_IDX_TRIM_BASE + 12'h002, 32'h08);
		wb(1, `OVR_IDX_TRIM_BASE + 12'h004, 32'h08);
		put(12'h800, 12'h000);
		check({link.samp_b, link.samp_a}, {12'h008, 12'h808});
		@(posedge clk_i);
		#1;
		check({link.dual_mode, hov}, 3'b011);
		repeat (12) @(posedge clk_i);
		wb(1, `OVR_IDX_IRQ_STAT, 32'h1f);
		wb(1, `OVR_IDX_CTRL, 32'h7);
		rdchk(`OVR_IDX_STATUS, 1);
		put(12'h7f0, 12'h000);
		check(link.chan_a_high_flag, 0);
		repeat (20) @(posedge clk_i);
		rdchk(`OVR_IDX_STATUS, 0);
		wb(0, `OVR_IDX_IRQ_STAT, 0);
		check(rd[4], 1);
		wb(1, `OVR_IDX_CTRL, 32'h5);
		rdchk(`OVR_IDX_STATUS, 0);
		put(12'h7f0, 12'h000);
		check(link.chan_a_high_flag, 1);
		n = 0;
		repeat (40) begin
			@(posedge clk_i);
			#1;
			n += (gup === 1'b1);
		end
		check(n > 0, 1);
		stop_test();
	end
endmodule
